// ===== hw/bbs_pkg.sv
// Package for the battery-backed SRAM host controller
package bbs_pkg;

   // ***********************************************************
   // Geometry
   // ***********************************************************
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;

   // ***********************************************************
   // Timing in ns, recovery in ms, and clock period
   // ***********************************************************
   localparam int CLK_NS = 4;
   localparam int T_CYCLE_NS = 70;     // Read/write cycle time, -70 grade
   localparam int T_AVQV_NS = 70;      // Address access time
   localparam int T_WLWH_NS = 55;      // Write strobe width
   localparam int T_WHAX_NS = 5;       // Strobe high to address change
   localparam int T_DH_NS = 10;        // Data hold after strobe rises
   localparam int T_GHQZ_NS = 20;      // Output enable high to Hi-Z
   localparam int T_RECOV_MS = 40;     // Power-up recovery, least

   // Access least times round up to whole cycles; recovery truncates
   localparam int CYC_CYCLE = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_AVQV = (T_AVQV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_WLWH = (T_WLWH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_WHAX = (T_WHAX_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_DH = (T_DH_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_GHQZ = (T_GHQZ_NS + CLK_NS - 1) / CLK_NS;
   localparam int CYC_RECOV = T_RECOV_MS * 1000000 / CLK_NS;

   localparam int CNT_W = 24;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
   } bbs_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr_bus;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
      logic chip_sel_n;
      logic out_en_n;
      logic write_n;
   } bbs_pins_t;

   typedef enum logic [2:0] {
      ST_RECOVER = 3'h0,
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h3,
      ST_HOLD = 3'h4,
      ST_GAP = 3'h5
   } bbs_state_t;

endpackage : bbs_pkg

// ===== hw/bbs_timer.sv
// Down counter that times each phase of an access
`timescale 1ns/10ps
module bbs_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] value,
   // Status
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } bbs_tmr_t;

   bbs_tmr_t cur_ff, nxt_cur;

   // Load wins, otherwise count down to zero
   always_comb begin
      nxt_cur = cur_ff;
      if (load) begin
         nxt_cur.cnt = value;
      end else if (cur_ff.cnt != '0) begin
         nxt_cur.cnt = cur_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Done looks at the count only; gating by load would loop back
   // through the sequencer, which raises load when it sees done
   assign done = (cur_ff.cnt == '0);

endmodule : bbs_timer

// ===== hw/bbs_ctrl.sv
// Host controller for the battery-backed asynchronous byte SRAM
// Operation
// - Controller holds address stable until the terminating edge.
// - Terminating strobe stays high a minimum time before next cycle.
// - Write data valid before end and held after terminating edge.
// - Output enable stays high throughout write cycles.
`timescale 1ns/10ps
module bbs_ctrl
   import bbs_pkg::*;
#(
   parameter int RECOV_CYC = CYC_RECOV
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Request side
   input wire logic req_valid,
   input wire bbs_pkg::bbs_req_t req,
   output logic req_ready,
   // Answer side
   output logic rsp_valid,
   output logic [bbs_pkg::DATA_W-1:0] rsp_data,
   output logic rsp_err,
   // Supply monitor
   input wire logic power_ok,
   // Memory pins
   output bbs_pkg::bbs_pins_t pins,
   input wire logic [bbs_pkg::DATA_W-1:0] data_in
);
   import bbs_pkg::*;

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      bbs_state_t st;
      bbs_pins_t pins;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic rsp_err;
      logic tmr_armed; // Recovery timer loaded since reset
   } bbs_ctl_t;

   bbs_ctl_t cur_ff, nxt_cur;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_val;
   logic tmr_done;

   // Phase timer
   bbs_timer #(.W(CNT_W)) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(tmr_load),
      .value(tmr_val),
      .done(tmr_done)
   );

   assign req_ready = (cur_ff.st == ST_IDLE) && power_ok;

   // ***********************************************************
   // Access sequencer
   // ***********************************************************
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.rsp_valid = 1'b0;
      tmr_load = 1'b0;
      tmr_val = '0;
      case (cur_ff.st)
         ST_RECOVER: begin
            // Wait out recovery after reset or after power returns
            if (!power_ok || !cur_ff.tmr_armed) begin
               tmr_load = 1'b1;
               tmr_val = CNT_W'(RECOV_CYC);
               nxt_cur.tmr_armed = 1'b1;
            end else if (tmr_done) begin
               nxt_cur.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (!power_ok) begin
               nxt_cur.st = ST_RECOVER;
               tmr_load = 1'b1;
               tmr_val = CNT_W'(RECOV_CYC);
            end else if (req_valid) begin
               nxt_cur.pins.addr_bus = req.addr;
               nxt_cur.pins.chip_sel_n = 1'b0;
               tmr_load = 1'b1;
               if (req.write) begin
                  // Drive data, keep output enable high
                  nxt_cur.pins.out_en_n = 1'b1;
                  nxt_cur.pins.write_n = 1'b0;
                  nxt_cur.pins.data_out = req.wdata;
                  nxt_cur.pins.data_oe = 1'b1;
                  nxt_cur.st = ST_WRITE;
                  tmr_val = CNT_W'(CYC_WLWH);
               end else begin
                  nxt_cur.pins.out_en_n = 1'b0;
                  nxt_cur.pins.write_n = 1'b1;
                  nxt_cur.st = ST_READ;
                  tmr_val = CNT_W'(CYC_AVQV);
               end
            end
         end
         ST_READ: begin
            // Sample only after full access time
            if (tmr_done) begin
               nxt_cur.rsp_data = data_in;
               nxt_cur.rsp_err = !power_ok;
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.pins.chip_sel_n = 1'b1;
               nxt_cur.pins.out_en_n = 1'b1;
               nxt_cur.st = ST_HOLD;
               tmr_load = 1'b1;
               tmr_val = CNT_W'(CYC_GHQZ);
            end
         end
         ST_WRITE: begin
            // Strobe ends the cycle first
            if (tmr_done) begin
               nxt_cur.pins.write_n = 1'b1;
               nxt_cur.rsp_err = !power_ok;
               nxt_cur.rsp_valid = 1'b1;
               nxt_cur.st = ST_HOLD;
               tmr_load = 1'b1;
               tmr_val = CNT_W'(CYC_DH);
            end
         end
         ST_HOLD: begin
            // Address and data held past terminating edge
            if (tmr_done) begin
               nxt_cur.pins.chip_sel_n = 1'b1;
               nxt_cur.pins.data_oe = 1'b0;
               nxt_cur.st = ST_GAP;
               tmr_load = 1'b1;
               tmr_val = CNT_W'(CYC_CYCLE - CYC_WLWH - CYC_DH);
            end
         end
         ST_GAP: begin
            // Strobe-high gap and full cycle spacing
            if (tmr_done) begin
               nxt_cur.st = ST_IDLE;
            end
         end
         default: begin
            nxt_cur.st = ST_RECOVER;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur_ff.st <= ST_RECOVER;
         cur_ff.pins <= '{addr_bus: '0, data_out: '0, data_oe: 1'b0,
                          chip_sel_n: 1'b1, out_en_n: 1'b1,
                          write_n: 1'b1};
         cur_ff.rsp_valid <= 1'b0;
         cur_ff.rsp_data <= '0;
         cur_ff.rsp_err <= 1'b0;
         cur_ff.tmr_armed <= 1'b0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign pins = cur_ff.pins;
   assign rsp_valid = cur_ff.rsp_valid;
   assign rsp_data = cur_ff.rsp_data;
   assign rsp_err = cur_ff.rsp_err;

   // ***********************************************************
   // Checks
   // ***********************************************************
   chk_no_contention: assert property (
      @(posedge sys_clk) disable iff (rst)
      pins.data_oe |-> pins.out_en_n)
      else $error("output enable low while driving data");

   chk_addr_stable: assert property (
      @(posedge sys_clk) disable iff (rst)
      !pins.write_n |=> $stable(pins.addr_bus))
      else $error("address moved during write");

   chk_strobe_width: assert property (
      @(posedge sys_clk) disable iff (rst)
      $fell(pins.write_n) |-> !pins.write_n [*8])
      else $error("write strobe too short");

   chk_data_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(pins.write_n) |-> pins.data_oe [*2])
      else $error("write data not held");

   chk_read_access: assert property (
      @(posedge sys_clk) disable iff (rst)
      $fell(pins.out_en_n) |-> !rsp_valid [*8])
      else $error("read answered before access time");

   chk_read_answer: assert property (
      @(posedge sys_clk) disable iff (rst)
      $fell(pins.out_en_n) |-> ##[17:20] rsp_valid)
      else $error("read answer late");

   chk_cycle_gap: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(pins.chip_sel_n) |-> pins.chip_sel_n [*3])
      else $error("cycles too close");

   chk_no_early: assert property (
      @(posedge sys_clk) disable iff (rst)
      !power_ok |=> !req_ready [*2])
      else $error("ready during power fail");

endmodule : bbs_ctrl

// ===== tb/bbs_sram_model.sv
// Behavioural model of the battery-backed byte SRAM
`timescale 1ns/10ps
module bbs_sram_model
   import bbs_pkg::*;
#(
   parameter int RECOV = 20, // Power-up recovery, cycles
   parameter int WP = 10 // Write-protect delay after supply loss, cycles
) (
   // Clock and supply
   input wire logic sys_clk,
   input wire logic power_ok,
   // Pins from the host
   input wire bbs_pkg::bbs_pins_t pins,
   input wire logic [bbs_pkg::DATA_W-1:0] bus,
   // Data driven back
   output logic [bbs_pkg::DATA_W-1:0] q,
   output logic q_oe
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] a_ff;
   logic [DATA_W-1:0] junk_ff = 8'h3c;
   logic wr_ff = 1'b0;
   int acc_ff = 0;
   int up_ff = 0;
   int dn_ff = 0;
   logic live;
   logic wr_now;
   // Accesses honoured only after recovery and before protection
   assign live = up_ff >= RECOV && dn_ff < WP;
   assign wr_now = live && !pins.chip_sel_n && !pins.write_n;
   assign q_oe = live && !pins.chip_sel_n && !pins.out_en_n
      && pins.write_n;
   // Junk until the address has been stable a full access time
   assign q = (acc_ff + 1 >= CYC_AVQV) ? mem[pins.addr_bus]
      : junk_ff;
   // Supply counters, access timer and write commit
   always @(posedge sys_clk) begin
      dn_ff <= power_ok ? 0 : dn_ff + 1;
      if (dn_ff >= WP) begin
         up_ff <= 0;
      end else if (power_ok && up_ff < RECOV) begin
         up_ff <= up_ff + 1;
      end
      junk_ff <= ~junk_ff ^ 8'h5a;
      acc_ff <= (!pins.chip_sel_n && pins.addr_bus == a_ff)
         ? acc_ff + 1 : 0;
      a_ff <= pins.addr_bus;
      if (wr_ff && !wr_now && live) begin
         mem[a_ff] <= bus;
      end
      wr_ff <= wr_now;
   end
endmodule : bbs_sram_model

// ===== tb/testbench.sv
// Self-checking testbench for the SRAM host controller
`timescale 1ns/10ps
module testbench;
   import bbs_pkg::*;
   typedef struct {logic [7:0] d; logic e; logic rd; int due;} bbs_exp_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic power_ok = 1'b1;
   bbs_req_t req = '0;
   bbs_pins_t pins;
   logic req_ready, rsp_valid, rsp_err, q_oe;
   logic [DATA_W-1:0] rsp_data, q, bus, bus_ff = 8'h00;
   int n_fail = 0, n_tests = 0, cyc = 0, seed = 32'hc337a16e;
   bbs_exp_t q_exp[$];
   bbs_exp_t ex;
   logic [7:0] shadow [int];
   logic [16:0] ad [8];
   // Released bus shows the inverse of its last level
   assign bus = pins.data_oe ? pins.data_out : q_oe ? q : ~bus_ff;
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      bus_ff <= bus;
   end
   bbs_ctrl #(.RECOV_CYC(20)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
      .power_ok(power_ok), .pins(pins), .data_in(bus));
   bbs_sram_model #(.RECOV(20), .WP(10)) u_mem (.sys_clk(sys_clk),
      .power_ok(power_ok), .pins(pins), .bus(bus), .q(q), .q_oe(q_oe));
   task automatic fail(input string m);
      $display("mismatch %0t %s", $time, m);
      n_fail++;
   endtask : fail
   // One request; expectation noted as it is taken
   task automatic xfer(input logic w, input logic [16:0] a,
         input logic [7:0] d, input logic e);
      int n = 0;
      req = '{addr: a, wdata: d, write: w};
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 5000) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n == 5000) fail("ready timeout");
      if (w) shadow[a] = d;
      q_exp.push_back('{shadow[a], e, !w,
         cyc + 2 + (w ? CYC_WLWH : CYC_AVQV)});
      @(posedge sys_clk);
      #1;
      req_valid = 1'b0;
      // Let an edge pass so valid never falls and rises in one step
      @(posedge sys_clk);
      #1;
   endtask : xfer
   // Supply drops mid-access, then recovery is timed
   task automatic pfail(input logic w, input logic [16:0] a);
      int n = 0;
      xfer(w, a, 8'hc5, 1'b1);
      repeat (6) @(posedge sys_clk);
      #1 power_ok = 1'b0;
      repeat (30) @(posedge sys_clk);
      #1 power_ok = 1'b1;
      while (req_ready !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      n_tests++;
      if (n < 20) fail("early ready");
      if (n == 200) fail("recovery timeout");
   endtask : pfail
   task automatic finish_test;
      $display("counts: %0d tests, %0d fails", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // Scoreboard: oldest expectation against each answer
   always @(negedge sys_clk) begin
      if (pins.data_oe === 1'b1 && q_oe === 1'b1) fail("fight");
      if (rsp_valid === 1'b1) begin
         n_tests++;
         if (q_exp.size() == 0) begin
            fail("unexpected answer");
         end else begin
            ex = q_exp.pop_front();
            if (cyc != ex.due) fail("answer timing");
            if (rsp_err !== ex.e) fail("error flag");
            if (ex.rd && !ex.e && rsp_data !== ex.d) fail("data");
         end
      end
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 rst = 1'b0;
      foreach (ad[i]) ad[i] = (i < 2) ? {17{i[0]}} : 17'($random(seed));
      foreach (ad[i]) xfer(1'b1, ad[i], 8'($random(seed)), 1'b0);
      foreach (ad[i]) xfer(1'b0, ad[i], 8'h00, 1'b0);
      $display("test boundary and random done");
      pfail(1'b1, ad[2]);
      xfer(1'b0, ad[2], 8'h00, 1'b0);
      pfail(1'b0, ad[3]);
      xfer(1'b0, ad[3], 8'h00, 1'b0);
      $display("test power fail done");
      repeat (40) @(posedge sys_clk);
      if (q_exp.size() != 0) fail("answers missing");
      finish_test();
   end
   // Watchdog
   initial begin
      #100000;
      fail("watchdog");
      finish_test();
   end
endmodule : testbench
